//--- service_save_exit_handler.sv
// Save and exit command handler of the service-mode command interpreter.
// Assumes a receiver on the same clock delivering one character per
// rx_valid pulse, a formatter turning response codes into text, and a
// flash controller answering each write request with one done pulse.
//
// Notes on behaviour
// [R1] Confirmed save writes working configuration to flash
// [R2] Count saves; warn when count exceeds limit
// [R3] Flash write always attempted despite warning
// [R4] Save proceeds only on upper-case Y
// [R5] Non-Y answer reverts changed transmission settings
// [R6] Answer N: no write, report aborted
// [R7] Other answer: abort and report invalid parameter
// [R8] Success reports new save count, then prompt
// [R9] Characters after save letter: wrong parameter count
// [R10] Emit maximum-saves warning past the limit
// [R11] Failed flash write: emit save-failure code
// [R12] Bad command unknown; bad value invalid parameter
// [R13] Exit with wrong parameter count or comma
// [R14] Target n: Normal Mode, confirm if dirty
// [R15] Target i: Init Mode, confirm if dirty
// [R16] Targets n, i wait three seconds hold
// [R17] Target N: Normal Mode at once
// [R18] Target I: Init Mode at once
// [R19] Init Mode entry reloads flash configuration
// [R20] Exit answer N: stay, return prompt
// [R21] Other exit answer: invalid parameter, stay
// [R22] Dirty flag tracks unsaved parameter changes
`include "save_exit_params.svh"
`default_nettype none

module service_save_exit_handler #(
	parameter int unsigned HOLD_CYCLES = `HOLD_TIME_S * `CLK_HZ
) (
	input  wire logic                      clock,
	input  wire logic                      rstn,
	input  wire logic                      service_active,
	input  wire logic                      rx_valid,
	input  wire logic [7:0]                rx_char,
	input  wire logic                      param_changed,
	input  wire logic                      tx_params_changed,
	input  wire logic                      flash_done,
	input  wire logic                      flash_ok,
	input  wire logic                      count_load,
	input  wire logic [`SAVE_COUNT_W-1:0]  count_load_value,
	output logic                           resp_valid,
	output save_exit_pkg::resp_t           resp_code,
	output logic                           flash_write_req,
	output logic [`SAVE_COUNT_W-1:0]       save_count,
	output logic                           params_dirty,
	output logic                           tx_revert,
	output logic                           reload_req,
	output logic                           enter_normal,
	output logic                           enter_init
);
	import save_exit_pkg::*;

	// ------------------------------------------------------------
	// Internal state
	// ------------------------------------------------------------
	state_t                      state_reg;       // Parser and sequencer state
	resp_t                       err_reg;         // Error waiting to be emitted
	logic                        extra_reg;       // Characters seen after save letter
	logic                        go_init_reg;     // Exit target is Init Mode
	logic [31:0]                 hold_cnt_reg;    // Cycles spent in the hold
	logic                        hold_done;       // Hold time has elapsed
	logic                        save_ok;         // Flash write finished well
	logic                        arg_ok;          // Exit target character known
	logic                        arg_now;         // Exit target asks no wait
	logic                        arg_init;        // Exit target is Init Mode
	logic [7:0]                  arg_reg;         // Stored exit target character
	logic                        over_limit;      // Save counter past the limit

	// ------------------------------------------------------------
	// Decodes
	// ------------------------------------------------------------

	// Classify the stored exit target character
	always_comb begin
		arg_ok   = 1'b1;
		arg_now  = 1'b0;
		arg_init = 1'b0;
		if (arg_reg == `CH_NORMAL_LO) begin
			arg_now = 1'b0;
		end else if (arg_reg == `CH_INIT_LO) begin
			arg_init = 1'b1;
		end else if (arg_reg == `CH_NORMAL_UP) begin
			arg_now = 1'b1;
		end else if (arg_reg == `CH_INIT_UP) begin
			arg_now  = 1'b1;
			arg_init = 1'b1;
		end else begin
			arg_ok = 1'b0;
		end
	end

	// Flash write completed successfully
	assign save_ok    = (state_reg == ST_S_WRITE) && flash_done && flash_ok;
	// Counter already shows more saves than the flash is rated for
	assign over_limit = (save_count > `SAVE_LIMIT);    // [R2]
	// Last cycle of the hold time
	assign hold_done  = (hold_cnt_reg == HOLD_CYCLES - 32'd1);

	// ------------------------------------------------------------
	// Exit target capture
	// ------------------------------------------------------------

	// Keep the target character while the command completes
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			arg_reg <= 8'h00;
		end else if (state_reg == ST_X_ARG && rx_valid) begin
			arg_reg <= rx_char;
		end
	end

	// ------------------------------------------------------------
	// Parser and sequencer
	// ------------------------------------------------------------

	// One character per rx_valid; responses one per cycle
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state_reg       <= ST_IDLE;
			err_reg         <= RSP_E001;
			extra_reg       <= 1'b0;
			go_init_reg     <= 1'b0;
			resp_valid      <= 1'b0;
			resp_code       <= RSP_PROMPT;
			flash_write_req <= 1'b0;
			tx_revert       <= 1'b0;
			reload_req      <= 1'b0;
			enter_normal    <= 1'b0;
			enter_init      <= 1'b0;
		end else begin
			// Pulses last one cycle
			resp_valid   <= 1'b0;
			tx_revert    <= 1'b0;
			reload_req   <= 1'b0;
			enter_normal <= 1'b0;
			enter_init   <= 1'b0;
			case (state_reg)
				ST_IDLE: begin
					// Command letter
					if (rx_valid && service_active) begin
						if (rx_char == `CH_SAVE_LO || rx_char == `CH_SAVE_UP) begin
							extra_reg <= 1'b0;
							state_reg <= ST_S_TAIL;
						end else if (rx_char == `CH_EXIT_LO || rx_char == `CH_EXIT_UP) begin
							state_reg <= ST_X_SEP;
						end else if (rx_char == `CH_CR) begin
							// Empty line: prompt again
							resp_valid <= 1'b1;
							resp_code  <= RSP_PROMPT;
						end else begin
							err_reg   <= RSP_E001;    // [R12]
							state_reg <= ST_SKIP;
						end
					end
				end
				ST_SKIP: begin
					// Drop the rest of a bad line
					if (rx_valid && rx_char == `CH_CR) begin
						state_reg <= ST_EMIT_ERR;
					end
				end
				ST_S_TAIL: begin
					// Save takes no parameters
					if (rx_valid) begin
						if (rx_char != `CH_CR) begin
							extra_reg <= 1'b1;
						end else if (extra_reg) begin
							err_reg   <= RSP_E002;    // [R9]
							state_reg <= ST_EMIT_ERR;
						end else begin
							resp_valid <= 1'b1;
							resp_code  <= RSP_SAVE_CONFIRM;    // [R4]
							state_reg  <= ST_S_CONF;
						end
					end
				end
				ST_S_CONF: begin
					// Confirmation answer
					if (rx_valid) begin
						if (rx_char == `CH_YES) begin
							flash_write_req <= 1'b1;    // [R1] [R3] [R4]
							state_reg       <= ST_S_WRITE;
							if (over_limit) begin
								resp_valid <= 1'b1;
								resp_code  <= RSP_E004;    // [R2] [R10]
							end
						end else begin
							resp_valid <= 1'b1;
							resp_code  <= RSP_ABORTED;    // [R6] [R7]
							tx_revert  <= tx_params_changed;    // [R5]
							if (rx_char == `CH_NO) begin
								state_reg <= ST_EMIT_PROMPT;    // [R6]
							end else begin
								err_reg   <= RSP_E003;    // [R7]
								state_reg <= ST_EMIT_ERR;
							end
						end
					end
				end
				ST_S_WRITE: begin
					// Wait for the flash controller
					if (flash_done) begin
						flash_write_req <= 1'b0;
						resp_valid      <= 1'b1;
						state_reg       <= ST_EMIT_PROMPT;    // [R8]
						if (flash_ok) begin
							resp_code <= RSP_SAVED;    // [R8]
						end else begin
							resp_code <= RSP_E005;    // [R11]
						end
					end
				end
				ST_X_SEP: begin
					// Exit needs a space before its target
					if (rx_valid) begin
						if (rx_char == `CH_SP) begin
							state_reg <= ST_X_ARG;
						end else if (rx_char == `CH_CR) begin
							err_reg   <= RSP_E002;    // [R13]
							state_reg <= ST_EMIT_ERR;
						end else if (rx_char == `CH_COMMA) begin
							err_reg   <= RSP_E002;    // [R13]
							state_reg <= ST_SKIP;
						end else begin
							err_reg   <= RSP_E001;    // [R12]
							state_reg <= ST_SKIP;
						end
					end
				end
				ST_X_ARG: begin
					// Target character
					if (rx_valid) begin
						if (rx_char == `CH_CR) begin
							err_reg   <= RSP_E002;    // [R13]
							state_reg <= ST_EMIT_ERR;
						end else if (rx_char == `CH_COMMA || rx_char == `CH_SP) begin
							err_reg   <= RSP_E002;    // [R13]
							state_reg <= ST_SKIP;
						end else begin
							state_reg <= ST_X_TAIL;
						end
					end
				end
				ST_X_TAIL: begin
					// Line must end right after the target
					if (rx_valid) begin
						if (rx_char != `CH_CR) begin
							err_reg   <= RSP_E002;    // [R13]
							state_reg <= ST_SKIP;
						end else if (!arg_ok) begin
							err_reg   <= RSP_E003;    // [R12]
							state_reg <= ST_EMIT_ERR;
						end else if (arg_now) begin
							// Immediate exit, no question, no hold
							resp_valid   <= 1'b1;
							resp_code    <= arg_init ? RSP_TO_INIT : RSP_TO_NORMAL;
							enter_normal <= !arg_init;    // [R17]
							enter_init   <= arg_init;    // [R18]
							reload_req   <= arg_init;    // [R19]
							state_reg    <= ST_IDLE;
						end else if (params_dirty) begin
							resp_valid  <= 1'b1;
							resp_code   <= RSP_EXIT_CONFIRM;    // [R14] [R15]
							go_init_reg <= arg_init;
							state_reg   <= ST_X_CONF;
						end else begin
							resp_valid  <= 1'b1;
							resp_code   <= arg_init ? RSP_TO_INIT : RSP_TO_NORMAL;
							go_init_reg <= arg_init;
							state_reg   <= ST_HOLD;    // [R16]
						end
					end
				end
				ST_X_CONF: begin
					// Exit confirmation answer
					if (rx_valid) begin
						if (rx_char == `CH_YES) begin
							resp_valid <= 1'b1;
							resp_code  <= go_init_reg ? RSP_TO_INIT : RSP_TO_NORMAL;
							state_reg  <= ST_HOLD;    // [R14] [R15] [R16]
						end else if (rx_char == `CH_NO) begin
							resp_valid <= 1'b1;
							resp_code  <= RSP_PROMPT;    // [R20]
							state_reg  <= ST_IDLE;
						end else begin
							err_reg   <= RSP_E003;    // [R21]
							state_reg <= ST_EMIT_ERR;
						end
					end
				end
				ST_HOLD: begin
					// Mode change once the hold has run out
					if (hold_done) begin
						enter_normal <= !go_init_reg;    // [R14] [R16]
						enter_init   <= go_init_reg;    // [R15] [R16]
						reload_req   <= go_init_reg;    // [R19]
						state_reg    <= ST_IDLE;
					end
				end
				ST_EMIT_ERR: begin
					// Pending error code
					resp_valid <= 1'b1;
					resp_code  <= err_reg;
					state_reg  <= ST_EMIT_PROMPT;
				end
				ST_EMIT_PROMPT: begin
					// Ready prompt closes the command
					resp_valid <= 1'b1;
					resp_code  <= RSP_PROMPT;    // [R8] [R21]
					state_reg  <= ST_IDLE;
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Hold timer
	// ------------------------------------------------------------

	// Counts cycles while a delayed exit waits
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			hold_cnt_reg <= 32'h00000000;
		end else if (state_reg == ST_HOLD) begin
			hold_cnt_reg <= hold_cnt_reg + 32'd1;    // [R16]
		end else begin
			hold_cnt_reg <= 32'h00000000;
		end
	end

	// ------------------------------------------------------------
	// Save counter
	// ------------------------------------------------------------

	// Loaded from flash by the system, bumped on every good save
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			save_count <= `SAVE_COUNT_RST;
		end else if (save_ok) begin
			save_count <= save_count + 32'd1;    // [R2] [R8]
		end else if (count_load) begin
			save_count <= count_load_value;
		end
	end

	// ------------------------------------------------------------
	// Unsaved change flag
	// ------------------------------------------------------------

	// Set wins over a clear in the same cycle
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			params_dirty <= 1'b0;
		end else if (param_changed) begin
			params_dirty <= 1'b1;    // [R22]
		end else if (save_ok || reload_req) begin
			params_dirty <= 1'b0;    // [R22] [R19]
		end
	end

endmodule

`default_nettype wire

//--- save_exit_params.svh
// Constants for the save and exit command handler.
// Assumes inclusion by bare name from the design module and the checker.
`ifndef SAVE_EXIT_PARAMS_SVH
`define SAVE_EXIT_PARAMS_SVH

// ASCII characters seen on the command line
`define CH_CR         8'h0D
`define CH_SP         8'h20
`define CH_COMMA      8'h2C
`define CH_SAVE_LO    8'h73
`define CH_SAVE_UP    8'h53
`define CH_EXIT_LO    8'h78
`define CH_EXIT_UP    8'h58
`define CH_YES        8'h59
`define CH_NO         8'h4E
`define CH_NORMAL_LO  8'h6E
`define CH_NORMAL_UP  8'h4E
`define CH_INIT_LO    8'h69
`define CH_INIT_UP    8'h49

// Save counter
`define SAVE_COUNT_W  32
`define SAVE_LIMIT    32'h00002710
`define SAVE_COUNT_RST 32'h00000000

// Hold time before a delayed exit
`define HOLD_TIME_S   3
`define CLK_HZ        25000000

`endif

//--- save_exit_pkg.sv
// Types shared by the save and exit command handler.
// Assumes save_exit_params.svh sits in the same folder.
`default_nettype none

package save_exit_pkg;
	// Response codes handed to the text formatter
	typedef enum logic [3:0] {
		RSP_PROMPT       = 4'h0,
		RSP_SAVE_CONFIRM = 4'h1,
		RSP_SAVED        = 4'h2,
		RSP_ABORTED      = 4'h3,
		RSP_EXIT_CONFIRM = 4'h4,
		RSP_TO_NORMAL    = 4'h5,
		RSP_TO_INIT      = 4'h6,
		RSP_E001         = 4'h7,
		RSP_E002         = 4'h8,
		RSP_E003         = 4'h9,
		RSP_E004         = 4'hA,
		RSP_E005         = 4'hB
	} resp_t;

	// Parser and sequencer states
	typedef enum logic [3:0] {
		ST_IDLE        = 4'h0,
		ST_SKIP        = 4'h1,
		ST_S_TAIL      = 4'h2,
		ST_S_CONF      = 4'h3,
		ST_S_WRITE     = 4'h4,
		ST_X_SEP       = 4'h5,
		ST_X_ARG       = 4'h6,
		ST_X_TAIL      = 4'h7,
		ST_X_CONF      = 4'h8,
		ST_HOLD        = 4'h9,
		ST_EMIT_ERR    = 4'hA,
		ST_EMIT_PROMPT = 4'hB
	} state_t;
endpackage

`default_nettype wire

//--- save_exit_chk.sv
// Assertion checker for the save and exit handler, bound to its top module.
// Assumes save_exit_pkg is compiled first and the params header is on the path.
`include "save_exit_params.svh"
`default_nettype none

module save_exit_chk
	import save_exit_pkg::*;
#(
	parameter int unsigned HOLD_CYCLES = 20
) (
	input wire logic                     clock,
	input wire logic                     rstn,
	input wire logic                     param_changed,
	input wire logic                     flash_done,
	input wire logic                     flash_ok,
	input wire logic                     resp_valid,
	input var  save_exit_pkg::resp_t     resp_code,
	input wire logic                     flash_write_req,
	input wire logic [`SAVE_COUNT_W-1:0] save_count,
	input wire logic                     params_dirty,
	input wire logic                     reload_req,
	input wire logic                     enter_normal,
	input wire logic                     enter_init
);
	// ------------------------------------------------------------
	// Common clocking and step sequences
	// ------------------------------------------------------------
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	logic        wait_on;                   // A delayed exit has been announced
	logic [31:0] wait_cnt;                  // Cycles since that announcement

	// Counts from a delayed exit response up to the mode change pulse
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			wait_on  <= 1'b0;
			wait_cnt <= 32'h00000000;
		end else if (resp_valid && (resp_code == RSP_TO_NORMAL || resp_code == RSP_TO_INIT)
			&& !enter_normal && !enter_init) begin
			wait_on  <= 1'b1;
			wait_cnt <= 32'h00000001;
		end else if (enter_normal || enter_init) begin
			wait_on  <= 1'b0;
		end else if (wait_on) begin
			wait_cnt <= wait_cnt + 32'h00000001;
		end
	end
	wire logic save_good;                   // Flash write ended well
	assign save_good = flash_write_req && flash_done && flash_ok;
	sequence s_saved;
		resp_valid && resp_code == RSP_SAVED;
	endsequence
	sequence s_prompt;
		resp_valid && resp_code == RSP_PROMPT;
	endsequence

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	save_report_a: assert property (save_good |=> s_saved ##1 s_prompt)
		else $error("save success not reported");
	count_step_a: assert property (save_good |=> save_count == $past(save_count) + 1)
		else $error("save counter did not step");
	fail_code_a: assert property (flash_write_req && flash_done && !flash_ok
		|=> resp_valid && resp_code == RSP_E005) else $error("flash failure not reported");
	wear_warn_a: assert property ($rose(flash_write_req) && save_count > `SAVE_LIMIT
		|-> resp_valid && resp_code == RSP_E004) else $error("wear warning missing");
	req_hold_a: assert property (flash_write_req && !flash_done |=> flash_write_req)
		else $error("flash write dropped early");
	dirty_set_a: assert property (param_changed |=> params_dirty)
		else $error("dirty flag not set");
	dirty_clr_a: assert property (save_good && !param_changed |=> !params_dirty)
		else $error("dirty flag not cleared");
	init_reload_a: assert property (enter_init |-> reload_req)
		else $error("init entry without reload");
	abort_dry_a: assert property (resp_valid && resp_code == RSP_ABORTED |-> !flash_write_req)
		else $error("write during aborted save");
	hold_wait_a: assert property (wait_on
		|-> ((enter_normal || enter_init) == (wait_cnt == HOLD_CYCLES)))
		else $error("hold time wrong");
endmodule

bind service_save_exit_handler save_exit_chk #(.HOLD_CYCLES(HOLD_CYCLES)) chk_i (
	.clock(clock), .rstn(rstn), .param_changed(param_changed), .flash_done(flash_done),
	.flash_ok(flash_ok), .resp_valid(resp_valid), .resp_code(resp_code),
	.flash_write_req(flash_write_req), .save_count(save_count),
	.params_dirty(params_dirty), .reload_req(reload_req),
	.enter_normal(enter_normal), .enter_init(enter_init));

`default_nettype wire

//--- flash_model.sv
// Behavioural flash controller answering the handler's write requests.
// Assumes one clock shared with the handler; fail is set by the bench.
`default_nettype none

module flash_model (
	input  wire logic clock,
	input  wire logic rstn,
	input  wire logic write_req,
	input  wire logic fail,
	output logic      done,
	output logic      ok
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] wait_cnt; // Cycles spent on current write
	logic       slow;     // Alternates quick and slow answers

	// ------------------------------------------------------------
	// Write answer: one done pulse, ok noisy outside it
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			wait_cnt <= 3'h0;
			done     <= 1'b0;
			ok       <= 1'b0;
			slow     <= 1'b0;
		end else if (write_req && !done && wait_cnt == (slow ? 3'h5 : 3'h1)) begin
			done     <= 1'b1;
			ok       <= !fail;
			wait_cnt <= 3'h0;
			slow     <= !slow;
		end else begin
			done     <= 1'b0;
			ok       <= !ok; // Meaningless outside done
			wait_cnt <= (write_req && !done) ? wait_cnt + 3'h1 : 3'h0;
		end
	end
endmodule

`default_nettype wire

//--- service_save_exit_handler_tb.sv
// Self-checking bench for the save and exit handler.
// Assumes the package, handler, flash model and checker are compiled first.
`default_nettype none

module service_save_exit_handler_tb;
	import save_exit_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock, rstn, service_active, rx_valid, param_changed, tx_params_changed;
	logic flash_done, flash_ok, count_load, fail, resp_valid, flash_write_req;
	logic params_dirty, tx_revert, reload_req, enter_normal, enter_init, prev_req;
	logic [7:0]  rx_char;
	logic [31:0] count_load_value, save_count;
	resp_t       resp_code;
	resp_t       seen[$]; // Responses of current command
	int errors, checks_done, n_norm, n_init, n_rel, n_rev, n_req;

	service_save_exit_handler #(.HOLD_CYCLES(20)) dut (.clock(clock), .rstn(rstn),
		.service_active(service_active), .rx_valid(rx_valid), .rx_char(rx_char),
		.param_changed(param_changed), .tx_params_changed(tx_params_changed),
		.flash_done(flash_done), .flash_ok(flash_ok), .count_load(count_load),
		.count_load_value(count_load_value), .resp_valid(resp_valid),
		.resp_code(resp_code), .flash_write_req(flash_write_req), .save_count(save_count),
		.params_dirty(params_dirty), .tx_revert(tx_revert), .reload_req(reload_req),
		.enter_normal(enter_normal), .enter_init(enter_init));
	flash_model flash_i (.clock(clock), .rstn(rstn), .write_req(flash_write_req),
		.fail(fail), .done(flash_done), .ok(flash_ok));

	// ------------------------------------------------------------
	// Clock, response and pulse monitor
	// ------------------------------------------------------------
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	always @(negedge clock) begin
		if (resp_valid === 1'b1) seen.push_back(resp_code);
		if (enter_normal === 1'b1) n_norm++;
		if (enter_init === 1'b1) n_init++;
		if (reload_req === 1'b1) n_rel++;
		if (tx_revert === 1'b1) n_rev++;
		if (flash_write_req === 1'b1 && prev_req !== 1'b1) n_req++;
		prev_req = flash_write_req;
	end

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic final_report;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic send(input byte c); // One character, then idle gap
		@(negedge clock);
		rx_valid = 1'b1;
		rx_char = c;
		@(negedge clock);
		rx_valid = 1'b0;
		repeat (3) @(negedge clock);
	endtask
	task automatic dirty; // Pulse a working parameter change
		@(negedge clock);
		param_changed = 1'b1;
		@(negedge clock);
		param_changed = 1'b0;
	endtask
	// Sends a line, compares codes (hex digits) and mode-change pulses
	task automatic run(input string cmd, input string exp, input int en, input int ei);
		int n0, i0, r0;
		n0 = n_norm;
		i0 = n_init;
		r0 = n_rel;
		seen.delete();
		foreach (cmd[k]) send(cmd[k]);
		repeat (40) @(negedge clock); // Covers the 20-cycle hold
		check(seen.size(), exp.len());
		for (int k = 0; k < exp.len(); k++)
			check(k < seen.size() ? seen[k] : 4'hF, 4'(exp[k] > "9" ? exp[k] - 55 : exp[k] - 48));
		check(n_norm - n0, en);
		check(n_init - i0, ei);
		check(n_rel - r0, ei);
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_save;
		@(negedge clock);
		count_load = 1'b1;
		count_load_value = 32'h00002710;
		@(negedge clock);
		count_load = 1'b0;
		dirty();
		run("s\rY", "120", 0, 0);
		check(save_count, 32'h00002711);
		check(params_dirty, 1'b0);
		run("S\rY", "1A20", 0, 0);
		check(save_count, 32'h00002712);
		fail = 1'b1;
		run("s\rY", "1AB0", 0, 0);
		check(save_count, 32'h00002712);
		fail = 1'b0;
		$display("save paths done");
	endtask
	task automatic t_abort;
		int r, q;
		r = n_rev;
		q = n_req;
		tx_params_changed = 1'b1;
		run("s\rN", "130", 0, 0);
		run("s\ry", "1390", 0, 0);
		check(n_rev - r, 2);
		check(n_req - q, 0);
		tx_params_changed = 1'b0;
		r = n_rev;
		run("s\rN", "130", 0, 0);
		check(n_rev - r, 0);
		run("s a\r", "80", 0, 0);
		$display("save abort done");
	endtask
	task automatic t_exit_clean;
		run("x n\r", "5", 1, 0);
		run("x i\r", "6", 0, 1);
		run("x N\r", "5", 1, 0);
		run("x I\r", "6", 0, 1);
		$display("clean exit done");
	endtask
	task automatic t_exit_dirty;
		dirty();
		run("x n\rY", "45", 1, 0);
		run("x i\rN", "40", 0, 0);
		run("x n\rq", "490", 0, 0);
		run("x i\rY", "46", 0, 1);
		check(params_dirty, 1'b0);
		dirty();
		run("x N\r", "5", 1, 0);
		$display("dirty exit done");
	endtask
	task automatic t_errors;
		run("x\r", "80", 0, 0);
		run("x,n\r", "80", 0, 0);
		run("x nn\r", "80", 0, 0);
		run("x q\r", "90", 0, 0);
		run("q\r", "70", 0, 0);
		run("\r", "0", 0, 0);
		service_active = 1'b0;
		run("s\r", "", 0, 0);
		service_active = 1'b1;
		$display("error paths done");
	endtask

	// ------------------------------------------------------------
	// Main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		{rstn, rx_valid, param_changed, tx_params_changed, count_load, fail} = 6'h00;
		{service_active, rx_char, count_load_value} = 41'h10000000000;
		repeat (2) @(posedge clock);
		@(negedge clock);
		rstn = 1'b1;
		check(save_count, 32'h00000000);
		t_save();
		t_abort();
		t_exit_clean();
		t_exit_dirty();
		t_errors();
		final_report();
	end
	initial begin
		repeat (20000) @(posedge clock);
		errors++;
		final_report();
	end
endmodule

`default_nettype wire
